// ---- shared/oag_defs.svh ----
// constants for the operand address generator
`ifndef OAG_DEFS_SVH
`define OAG_DEFS_SVH
`define OAG_CLK_PER_MC      4
`define OAG_CLK_PER_TICK    12
`define OAG_MC_MAX          5
`define OAG_EXT_MOVE_MC     2
`define OAG_MOVDD_MC        3
`define OAG_DIRECT_TOP      8'h7f
`define OAG_BITRAM_BASE     8'h20
`define OAG_BANK_BITS_LO    3
`endif

// ---- shared/oag_pkg.sv ----
// types for the operand address generator
package oag_pkg;
  typedef enum logic [2:0] {
    OAG_MODE_REG  = 3'h0,
    OAG_MODE_DIR  = 3'h1,
    OAG_MODE_BIT  = 3'h2,
    OAG_MODE_IND  = 3'h3,
    OAG_MODE_IMM  = 3'h4,
    OAG_MODE_XRI  = 3'h5,
    OAG_MODE_XDP  = 3'h6,
    OAG_MODE_TBL  = 3'h7
  } oag_mode_e;
  typedef enum logic [1:0] {
    OAG_SP_IRAM  = 2'h0,
    OAG_SP_PERI  = 2'h1,
    OAG_SP_XDATA = 2'h2,
    OAG_SP_CODE  = 2'h3
  } oag_space_e;
  typedef struct packed {
    oag_mode_e  mode;
    logic       use_stack;
    logic       sel_r1;
    logic       tbl_use_pc;
    logic [2:0] reg_num;
    logic [7:0] operand;
    logic [2:0] mc_count;
  } oag_req_s;
  typedef struct packed {
    oag_space_e space;
    logic [15:0] addr;
    logic [2:0]  bit_pos;
    logic        bit_op;
    logic [7:0]  imm;
  } oag_acc_s;
endpackage

// ---- hdl/oag_core.sv ----
// operand address generation and machine cycle timing
`timescale 1ns/1ns
`include "oag_defs.svh"
module oag_core
  import oag_pkg::*;
#(
  parameter int ONCHIP_CODE_TOP = 16'h1fff,
  parameter int HAS_ONCHIP_CODE = 1
)(
  input  wire logic        sys_clk,
  input  wire logic        sys_rst,
  input  wire logic        req_valid,
  input  oag_req_s         req,
  input  wire logic [1:0]  bank_sel,
  input  wire logic [7:0]  r0_val,
  input  wire logic [7:0]  r1_val,
  input  wire logic [7:0]  stack_ptr,
  input  wire logic [7:0]  port_two_latch,
  input  wire logic [15:0] first_data_pointer,
  input  wire logic [15:0] second_data_pointer,
  input  wire logic        data_pointer_sel,
  input  wire logic [15:0] prog_counter,
  input  wire logic [7:0]  accumulator,
  input  wire logic [15:0] fetch_addr,
  output logic             addr_latch,
  output logic             timer_tick,
  output logic             mc_end,
  output logic             instr_busy,
  output logic             acc_valid,
  output oag_acc_s         acc,
  output logic             fetch_onchip,
  output logic             acc_load
);
  // refuse code tops outside the 64k code space and non-boolean flags
  if (ONCHIP_CODE_TOP < 0 || ONCHIP_CODE_TOP > 16'hffff ||
      HAS_ONCHIP_CODE < 0 || HAS_ONCHIP_CODE > 1)
  begin
    $error("oag_core: bad on-chip code parameters");
  end

  ////////////////////////////////////////////////////////////////////////////
  // clock phase and timer prescale
  logic [1:0] phase_reg;
  logic [3:0] tick_cnt_reg;

  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
      phase_reg <= 2'h0;
    else
      phase_reg <= phase_reg + 2'h1;
  end

  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
      addr_latch <= 1'b0;
    else
      addr_latch <= (phase_reg == 2'h3);
  end

  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
      mc_end <= 1'b0;
    else
      mc_end <= (phase_reg == 2'h2);
  end

  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      tick_cnt_reg <= 4'h0;
      timer_tick   <= 1'b0;
    end
    else if (tick_cnt_reg == 4'(`OAG_CLK_PER_TICK - 1))
    begin
      tick_cnt_reg <= 4'h0;
      timer_tick   <= 1'b1;
    end
    else
    begin
      tick_cnt_reg <= tick_cnt_reg + 4'h1;
      timer_tick   <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // instruction length in machine cycles
  logic [2:0] mc_left_reg;
  logic [2:0] mc_len;
  wire        mc_edge = (phase_reg == 2'h3);
  wire        take    = req_valid && !instr_busy && mc_edge;

  always_comb
  begin
    mc_len = req.mc_count;
    if (req.mode == OAG_MODE_REG)
      mc_len = 3'h1;
    else if (req.mode == OAG_MODE_XDP)
      mc_len = 3'(`OAG_EXT_MOVE_MC);
    if (mc_len == 3'h0)
      mc_len = 3'h1;
    else if (mc_len > 3'(`OAG_MC_MAX))
      mc_len = 3'(`OAG_MC_MAX);
  end

  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      mc_left_reg <= 3'h0;
      instr_busy  <= 1'b0;
    end
    else if (take)
    begin
      mc_left_reg <= mc_len - 3'h1;
      instr_busy  <= (mc_len != 3'h1);
    end
    else if (mc_edge && mc_left_reg != 3'h0)
    begin
      mc_left_reg <= mc_left_reg - 3'h1;
      instr_busy  <= (mc_left_reg != 3'h1);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // operand address decode
  oag_acc_s    acc_next;
  logic [7:0]  ptr;
  logic [15:0] ext_pointer;

  always_comb
  begin
    ptr  = req.sel_r1 ? r1_val : r0_val;
    ext_pointer = data_pointer_sel ? second_data_pointer : first_data_pointer;
    acc_next = '0;
    unique case (req.mode)
      OAG_MODE_REG:
      begin
        acc_next.space = OAG_SP_IRAM;
        acc_next.addr  = {8'h00, 3'h0, bank_sel, req.reg_num};
      end
      OAG_MODE_DIR:
      begin
        acc_next.addr = {8'h00, req.operand};
        acc_next.space = (req.operand > `OAG_DIRECT_TOP) ?
                         OAG_SP_PERI : OAG_SP_IRAM;
      end
      OAG_MODE_BIT:
      begin
        acc_next.bit_op  = 1'b1;
        acc_next.bit_pos = req.operand[2:0];
        if (req.operand[7])
        begin
          acc_next.space = OAG_SP_PERI;
          acc_next.addr  = {8'h00, req.operand[7:3], 3'h0};
        end
        else
        begin
          acc_next.space = OAG_SP_IRAM;
          acc_next.addr  = {8'h00, `OAG_BITRAM_BASE + {4'h0, req.operand[6:3]}};
        end
      end
      OAG_MODE_IND:
      begin
        acc_next.space = OAG_SP_IRAM;
        acc_next.addr  = {8'h00, req.use_stack ? stack_ptr : ptr};
      end
      OAG_MODE_IMM:
      begin
        acc_next.space = OAG_SP_IRAM;
        acc_next.imm   = req.operand;
      end
      OAG_MODE_XRI:
      begin
        acc_next.space = OAG_SP_XDATA;
        acc_next.addr  = {port_two_latch, ptr};
      end
      OAG_MODE_XDP:
      begin
        acc_next.space = OAG_SP_XDATA;
        acc_next.addr  = ext_pointer;
      end
      OAG_MODE_TBL:
      begin
        acc_next.space = OAG_SP_CODE;
        acc_next.addr  = (req.tbl_use_pc ? prog_counter : ext_pointer) + {8'h00, accumulator};
      end
    endcase
  end

  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      acc       <= '0;
      acc_valid <= 1'b0;
      acc_load  <= 1'b0;
    end
    else
    begin
      acc_valid <= take;
      acc_load  <= take && (req.mode == OAG_MODE_TBL);
      if (take)
        acc <= acc_next;
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
      fetch_onchip <= 1'b0;
    else
      fetch_onchip <= (HAS_ONCHIP_CODE != 0) &&
                      ({16'h0, fetch_addr} <= 32'(ONCHIP_CODE_TOP));
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  logic [3:0] ale_gap_reg;
  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
      ale_gap_reg <= 4'h0;
    else if (addr_latch)
      ale_gap_reg <= 4'h1;
    else
      ale_gap_reg <= ale_gap_reg + 4'h1;
  end

  latch_period_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    addr_latch |=> !addr_latch [*3] ##1 addr_latch)
    else $error("latch pulse not every four clocks");

  latch_gap_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    ale_gap_reg <= 4'h4)
    else $error("latch pulse missing");

  tick_period_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    timer_tick |=> !timer_tick [*8] ##1 !timer_tick [*3] ##1 timer_tick)
    else $error("timer tick not every twelve clocks");

  reg_one_mc_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (take && req.mode == OAG_MODE_REG) |=> !instr_busy)
    else $error("register instruction longer than one cycle");

  ext_move_len_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (take && req.mode == OAG_MODE_XDP) |=> instr_busy [*4] ##1 !instr_busy)
    else $error("data pointer move not two cycles");

  direct_peri_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (take && req.mode == OAG_MODE_DIR && req.operand[7]) |=> acc.space == OAG_SP_PERI)
    else $error("direct high address not peripheral");

  indirect_ram_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (take && req.mode == OAG_MODE_IND) |=> acc.space == OAG_SP_IRAM)
    else $error("indirect access not in RAM");

  xri_page_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (take && req.mode == OAG_MODE_XRI) |=> acc.addr[15:8] == $past(port_two_latch))
    else $error("external page byte wrong");

  table_load_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    acc_load |-> acc_valid && acc.space == OAG_SP_CODE)
    else $error("table read load without code access");

  reg_bank_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (take && req.mode == OAG_MODE_REG) |=>
      acc.addr == {11'h000, $past(bank_sel), $past(req.reg_num)})
    else $error("working register outside selected bank");

  bit_ram_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (take && req.mode == OAG_MODE_BIT && !req.operand[7]) |=>
      acc.space == OAG_SP_IRAM && acc.addr[15:4] == 12'h002 && acc.bit_op)
    else $error("bit address outside bit RAM");

  ext_full_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (take && req.mode == OAG_MODE_XDP) |=>
      acc.addr == $past(data_pointer_sel ? second_data_pointer : first_data_pointer))
    else $error("external pointer address wrong");

  imm_byte_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (take && req.mode == OAG_MODE_IMM) |=> acc.imm == $past(req.operand))
    else $error("immediate byte wrong");

  len_range_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    mc_left_reg < 3'(`OAG_MC_MAX))
    else $error("instruction longer than five cycles");
endmodule

// ---- tb/oag_mem_model.sv ----
// far-side memory model: supplies the next instruction fetch address
`timescale 1ns/1ns
module oag_mem_model (
  input  wire logic        sys_clk,
  input  wire logic        addr_latch,
  output logic      [15:0] fetch_addr
);
  initial fetch_addr = 16'h1ffe;
  // each cycle fetches somewhere on either side of the on-chip code top
  always @(negedge sys_clk)
    if (addr_latch === 1'b1)
      fetch_addr <= 16'($urandom) & 16'h3fff;
endmodule

// ---- tb/tb.sv ----
// self-checking bench for the operand address generator
`timescale 1ns/1ns
`include "oag_defs.svh"
module tb;
  import oag_pkg::*;
  localparam logic [15:0] CODE_TOP = 16'h1fff;
  logic        sys_clk, sys_rst, req_valid, data_pointer_sel, mc_q;
  logic        addr_latch, timer_tick, mc_end, instr_busy, acc_valid, fetch_onchip, acc_load;
  logic  [1:0] bank_sel;
  logic  [7:0] r0_val, r1_val, stack_ptr, port_two_latch, accumulator;
  logic [15:0] first_data_pointer, second_data_pointer, prog_counter, fetch_addr, fa_q;
  oag_req_s    req;
  oag_acc_s    acc;
  int          fail_count, total_checks;
  int          al_gap = -1000;
  int          tk_gap = -1000;
////////////////////////////////////////////////////////////////////////////////
  oag_core #(
    .ONCHIP_CODE_TOP     (CODE_TOP),
    .HAS_ONCHIP_CODE     (1)
  ) oag_core_i (
    .sys_clk             (sys_clk),
    .sys_rst             (sys_rst),
    .req_valid           (req_valid),
    .req                 (req),
    .bank_sel            (bank_sel),
    .r0_val              (r0_val),
    .r1_val              (r1_val),
    .stack_ptr           (stack_ptr),
    .port_two_latch      (port_two_latch),
    .first_data_pointer  (first_data_pointer),
    .second_data_pointer (second_data_pointer),
    .data_pointer_sel    (data_pointer_sel),
    .prog_counter        (prog_counter),
    .accumulator         (accumulator),
    .fetch_addr          (fetch_addr),
    .addr_latch          (addr_latch),
    .timer_tick          (timer_tick),
    .mc_end              (mc_end),
    .instr_busy          (instr_busy),
    .acc_valid           (acc_valid),
    .acc                 (acc),
    .fetch_onchip        (fetch_onchip),
    .acc_load            (acc_load)
  );
  oag_mem_model oag_mem_model_i (.sys_clk(sys_clk), .addr_latch(addr_latch),
    .fetch_addr(fetch_addr));
////////////////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    total_checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
////////////////////////////////////////////////////////////////////////////////
  always @(posedge sys_clk)
  begin
    fa_q <= fetch_addr;
    mc_q <= mc_end;
    al_gap++;
    tk_gap++;
    if (addr_latch === 1'b1)
    begin
      if (al_gap > 0)
        check("latch_gap", `OAG_CLK_PER_MC, 16'(al_gap));
      if (al_gap > 0)
        check("mc_end", 16'h0001, {15'h0, mc_q});
      al_gap = 0;
    end
    if (timer_tick === 1'b1)
    begin
      if (tk_gap > 0)
        check("tick_gap", `OAG_CLK_PER_TICK, 16'(tk_gap));
      tk_gap = 0;
    end
  end
  always @(negedge sys_clk)
    if (!sys_rst && al_gap > -990)
      check("onchip", {15'h0, fa_q <= CODE_TOP}, {15'h0, fetch_onchip});
////////////////////////////////////////////////////////////////////////////////
  task automatic run_req(input oag_mode_e m);
    oag_acc_s    e;
    logic  [7:0] rr;
    logic [15:0] dp;
    int          len, n;
    @(negedge sys_clk);
    req = 20'($urandom);
    req.mode = m;
    {bank_sel, data_pointer_sel, r0_val, r1_val, stack_ptr, port_two_latch, accumulator} =
      43'({$urandom, $urandom});
    {first_data_pointer, second_data_pointer} = $urandom;
    prog_counter = 16'($urandom);
    rr = req.sel_r1 ? r1_val : r0_val;
    dp = data_pointer_sel ? second_data_pointer : first_data_pointer;
    len = (req.mc_count == 0) ? 1 : (req.mc_count > 5) ? 5 : int'(req.mc_count);
    if (m == OAG_MODE_REG)
      len = 1;
    if (m == OAG_MODE_XDP)
      len = `OAG_EXT_MOVE_MC;
    e = '0;
    case (m)
      OAG_MODE_REG: e.addr = {11'h0, bank_sel, req.reg_num};
      OAG_MODE_DIR: e.addr = {8'h0, req.operand};
      OAG_MODE_BIT: e.addr = req.operand[7] ? {8'h0, req.operand[7:3], 3'h0}
                                            : {12'h002, req.operand[6:3]};
      OAG_MODE_IND: e.addr = {8'h0, req.use_stack ? stack_ptr : rr};
      OAG_MODE_XRI: e.addr = {port_two_latch, rr};
      OAG_MODE_XDP: e.addr = dp;
      OAG_MODE_TBL: e.addr = (req.tbl_use_pc ? prog_counter : dp) + {8'h0, accumulator};
      default:      e.addr = 16'h0;
    endcase
    e.space = (m == OAG_MODE_XRI || m == OAG_MODE_XDP) ? OAG_SP_XDATA
            : (m == OAG_MODE_TBL) ? OAG_SP_CODE
            : ((m == OAG_MODE_DIR || m == OAG_MODE_BIT) && req.operand[7]) ? OAG_SP_PERI
            : OAG_SP_IRAM;
    req_valid = 1'b1;
    n = 0;
    do
    begin
      @(posedge sys_clk);
      #1;
      n++;
    end
    while (acc_valid !== 1'b1 && n < 40);
    if (acc_valid !== 1'b1)
    begin
      fail_count++;
      $display("Error acc_valid expected 1 seen %b", acc_valid);
      complete_run();
    end
    check("space", 16'(e.space), 16'(acc.space));
    if (m != OAG_MODE_IMM)
      check("addr", e.addr, acc.addr);
    if (m == OAG_MODE_IMM)
      check("imm", {8'h0, req.operand}, {8'h0, acc.imm});
    if (m == OAG_MODE_BIT)
      check("bit", {12'h0, 1'b1, req.operand[2:0]}, {12'h0, acc.bit_op, acc.bit_pos});
    check("load", {15'h0, m == OAG_MODE_TBL}, {15'h0, acc_load});
    @(negedge sys_clk);
    req_valid = 1'b0;
    n = 0;
    while (instr_busy === 1'b1 && n < 30)
    begin
      n++;
      @(negedge sys_clk);
    end
    check("busy", 16'((len - 1) * `OAG_CLK_PER_MC), 16'(n));
    if (n >= 30)
      complete_run();
  endtask
////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  initial
  begin
    void'($urandom(32'h9e25));
    sys_rst = 1'b1;
    req_valid = 1'b0;
    req = '0;
    {bank_sel, data_pointer_sel, r0_val, r1_val, stack_ptr, port_two_latch, accumulator} = '0;
    {first_data_pointer, second_data_pointer, prog_counter} = '0;
    repeat (4) @(negedge sys_clk);
    sys_rst = 1'b0;
    for (int k = 0; k < 96; k++)
      run_req(oag_mode_e'(k % 8));
    complete_run();
  end
endmodule
